// file: fpsc_regs.vh
// register offsets, field positions and reset values of the fp status/control bank
`ifndef FPSC_REGS_VH
`define FPSC_REGS_VH
`define FPSC_OFF_DEFAULT     8'h0c
`define FPSC_OFF_CTX_CTL     8'h04
`define FPSC_OFF_ACCESS      8'h88
`define FPSC_OFF_IRQ_MASK    8'h40
`define FPSC_RST_STATUS      32'h0000_0000
`define FPSC_RST_DEFAULT     32'h0000_0000
`define FPSC_RST_CTX_CTL     2'h3
`define FPSC_RST_ACCESS      4'h0
`define FPSC_RST_IRQ_MASK    5'h0f
`define FPSC_BIT_NEG         31
`define FPSC_BIT_ZERO        30
`define FPSC_BIT_CARRY       29
`define FPSC_BIT_OVFL        28
`define FPSC_BIT_ALT_HALF    26
`define FPSC_BIT_DNAN        25
`define FPSC_BIT_FLUSH       24
`define FPSC_ROUND_SELECT_HI        23
`define FPSC_ROUND_SELECT_LO        22
`define FPSC_BIT_AUTO_SAVE   31
`define FPSC_BIT_LAZY_SAVE   30
`define FPSC_ACC_HI          23
`define FPSC_ACC_LO          20
`define FPSC_STATUS_WMASK    32'hf7c0_009f
`define FPSC_DEFAULT_WMASK   32'h07c0_0000
`define FPSC_STICKY_MASK     32'h0000_009f
`define FPSC_CMP_EQUAL       2'h0
`define FPSC_CMP_LESS        2'h1
`define FPSC_CMP_GREATER     2'h2
`define FPSC_CMP_UNORDERED   2'h3
`define FPSC_NZCV_EQUAL      4'h6
`define FPSC_NZCV_LESS       4'h8
`define FPSC_NZCV_GREATER    4'h2
`define FPSC_NZCV_UNORDERED  4'h3
`define FPSC_ACC_DENIED      2'h0
`define FPSC_ACC_PRIV        2'h1
`define FPSC_ACC_FULL        2'h3
`endif

// file: fpsc_status_control.v
// fp status/control register, default register, access control and exception irq
//
// What this block does
// [RULE1] comparisons update flags in bits 31..28
// [RULE2] compare outcome maps to fixed flag patterns
// [RULE3] bit 26 selects alternative half format
// [RULE4] bit 25 forces default nan results
// [RULE5] bit 24 enables flush to zero
// [RULE6] bits 23:22 select the rounding mode
// [RULE7] sticky bits set on exception, cleared by zero
// [RULE8] status not mapped, core transfers only, resets zero
// [RULE9] default register at 0x0c resets zero
// [RULE10] software keeps default reserved bits zero
// [RULE11] unit disabled at reset until software enables
// [RULE12] software enables both coprocessor fields then syncs
// [RULE13] access register only reachable when privileged
// [RULE14] sticky flags other than bit 0 ored into one interrupt request
// [RULE15] variant without mask, inexact never interrupts
// [RULE16] variant with masks, inexact masked by default
// [RULE17] plain config: handler clears stickies by write
// [RULE18] lazy save: read forces save and clear
// [RULE19] auto save: read forces status clear
// [RULE20] context bit 30 enables lazy preservation
// [RULE21] access field 00 faults, 01 privileged, 11 full
// [RULE22] reserved status bits ignore writes, read zero
// [RULE23] irq stays while any unmasked sticky set
`timescale 1ns/1ns
`default_nettype none
`include "fpsc_regs.vh"

module fpsc_status_control
#(
  parameter MASKED_VARIANT = 1
)
(
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        fp_wr,
  input  wire [31:0] fp_wdata,
  input  wire        fp_rd,
  input  wire        cmp_valid,
  input  wire [1:0]  cmp_result,
  input  wire        exc_valid,
  input  wire [7:0]  exc_flags,
  input  wire        ctx_entry,
  input  wire        fp_instr,
  input  wire        fp_instr_priv,
  input  wire        sys_wr,
  input  wire        sys_rd,
  input  wire        sys_priv,
  input  wire [7:0]  sys_addr,
  input  wire [31:0] sys_wdata,
  output reg  [31:0] fp_rdata_r,
  output reg  [31:0] sys_rdata_r,
  output reg         sys_err_r,
  output reg         usage_fault_r,
  output reg         fp_enabled_r,
  output reg         alt_half_format_r,
  output reg         default_nan_select_r,
  output reg         flush_denormals_r,
  output reg  [1:0]  round_select_r,
  output reg         save_request_r,
  output reg         fp_irq_r
);

  // ************************************************************
  // state registers
  // ************************************************************
  reg  [31:0] status_r;
  reg  [31:0] status_nxt;
  reg  [31:0] default_r;
  reg  [1:0]  ctx_ctl_r;
  reg  [3:0]  access_r;
  reg  [4:0]  irq_mask_r;
  reg  [3:0]  nzcv;
  reg  [31:0] sys_rdata_nxt;
  reg         sys_err_nxt;

  wire        sys_ok;
  wire        lazy_save_enable;
  wire        auto_save_enable;
  wire [1:0]  fp_coproc_low;
  wire [1:0]  fp_coproc_high;
  wire        access_allowed;
  wire        read_clears;
  wire [4:0]  irq_src;
  wire        irq_any;

  assign lazy_save_enable = ctx_ctl_r[0]; // see [RULE20]
  assign auto_save_enable = ctx_ctl_r[1];
  assign fp_coproc_low    = access_r[1:0];
  assign fp_coproc_high   = access_r[3:2];
  assign sys_ok           = sys_priv; // see [RULE13]

  // ************************************************************
  // access checking per coprocessor field
  // ************************************************************
  // both fields must grant access; reserved code 10 treated as denied
  function acc_ok;
    input [1:0] fld;
    input       priv;
    begin
      case (fld)
        `FPSC_ACC_DENIED: acc_ok = 1'b0;
        `FPSC_ACC_PRIV:   acc_ok = priv;
        `FPSC_ACC_FULL:   acc_ok = 1'b1;
        default:          acc_ok = 1'b0;
      endcase
    end
  endfunction

  // see [RULE21] and [RULE11]
  assign access_allowed = acc_ok(fp_coproc_low, fp_instr_priv) &
                          acc_ok(fp_coproc_high, fp_instr_priv);

  // reads clear live status when any save scheme is enabled
  assign read_clears = fp_rd & (lazy_save_enable | auto_save_enable); // see [RULE18] [RULE19]

  // ************************************************************
  // interrupt sources: idc, ufc, ofc, dzc, ixc
  // ************************************************************
  assign irq_src = {status_r[4], status_r[7], status_r[3:1]}; // see [RULE14]

  generate
    if (MASKED_VARIANT != 0)
    begin : g_masked
      // per-source masks, inexact enabled only when its mask bit set
      assign irq_any = |(irq_src & irq_mask_r); // see [RULE16] [RULE23]
    end
    else
    begin : g_unmasked
      // inexact is not wired; no per-source mask
      assign irq_any = |irq_src[3:0]; // see [RULE15] [RULE23]
    end
  endgenerate

  // ************************************************************
  // comparison flag decode
  // ************************************************************
  always @*
  begin
    case (cmp_result) // see [RULE2]
      `FPSC_CMP_EQUAL:   nzcv = `FPSC_NZCV_EQUAL;
      `FPSC_CMP_LESS:    nzcv = `FPSC_NZCV_LESS;
      `FPSC_CMP_GREATER: nzcv = `FPSC_NZCV_GREATER;
      default:           nzcv = `FPSC_NZCV_UNORDERED;
    endcase
  end

  // ************************************************************
  // status next value: write/clear first, hardware sets win
  // ************************************************************
  always @*
  begin
    status_nxt = status_r;
    if (ctx_entry)
    begin
      // new fp context takes the default settings
      status_nxt = default_r & `FPSC_DEFAULT_WMASK;
    end
    if (read_clears)
    begin
      status_nxt = `FPSC_RST_STATUS; // see [RULE18] [RULE19]
    end
    if (fp_wr)
    begin
      status_nxt = fp_wdata & `FPSC_STATUS_WMASK; // see [RULE22] [RULE17]
    end
    if (cmp_valid && access_allowed)
    begin
      status_nxt[`FPSC_BIT_NEG:`FPSC_BIT_OVFL] = nzcv; // see [RULE1]
    end
    if (exc_valid && access_allowed)
    begin
      status_nxt = status_nxt | ({24'h0, exc_flags} & `FPSC_STICKY_MASK); // see [RULE7]
    end
  end

  // ************************************************************
  // system register read decode
  // ************************************************************
  always @*
  begin
    sys_rdata_nxt = 32'h0000_0000;
    sys_err_nxt   = 1'b0;
    if (sys_rd || sys_wr)
    begin
      if (!sys_ok)
      begin
        sys_err_nxt = 1'b1; // see [RULE13]
      end
      else
      begin
        case (sys_addr)
          `FPSC_OFF_DEFAULT:
            sys_rdata_nxt = default_r;
          `FPSC_OFF_CTX_CTL:
            sys_rdata_nxt = {auto_save_enable, lazy_save_enable, 30'h0};
          `FPSC_OFF_ACCESS:
            sys_rdata_nxt = {8'h00, access_r, 20'h00000};
          `FPSC_OFF_IRQ_MASK:
            sys_rdata_nxt = {27'h0, irq_mask_r};
          default:
            sys_err_nxt = 1'b1;
        endcase
      end
    end
    if (!sys_rd)
    begin
      sys_rdata_nxt = 32'h0000_0000;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      status_r             <= `FPSC_RST_STATUS; // see [RULE8]
      default_r            <= `FPSC_RST_DEFAULT; // see [RULE9]
      ctx_ctl_r            <= `FPSC_RST_CTX_CTL;
      access_r             <= `FPSC_RST_ACCESS; // see [RULE11]
      irq_mask_r           <= `FPSC_RST_IRQ_MASK;
      fp_rdata_r           <= 32'h0000_0000;
      sys_rdata_r          <= 32'h0000_0000;
      sys_err_r            <= 1'b0;
      usage_fault_r        <= 1'b0;
      fp_enabled_r         <= 1'b0;
      alt_half_format_r    <= 1'b0;
      default_nan_select_r <= 1'b0;
      flush_denormals_r    <= 1'b0;
      round_select_r       <= 2'h0;
      save_request_r       <= 1'b0;
      fp_irq_r             <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      // system register writes, privileged only
      if (sys_wr && sys_ok)
      begin
        case (sys_addr)
          `FPSC_OFF_DEFAULT:
            default_r <= sys_wdata & `FPSC_DEFAULT_WMASK; // see [RULE9] [RULE10]
          `FPSC_OFF_CTX_CTL:
            ctx_ctl_r <= {sys_wdata[`FPSC_BIT_AUTO_SAVE], sys_wdata[`FPSC_BIT_LAZY_SAVE]};
          `FPSC_OFF_ACCESS:
            access_r <= sys_wdata[`FPSC_ACC_HI:`FPSC_ACC_LO]; // see [RULE12]
          `FPSC_OFF_IRQ_MASK:
            irq_mask_r <= sys_wdata[4:0];
          default:
            irq_mask_r <= irq_mask_r;
        endcase
      end
      sys_rdata_r   <= sys_rdata_nxt;
      sys_err_r     <= sys_err_nxt;
      // live status read returns value before any clear
      fp_rdata_r    <= fp_rd ? status_r : 32'h0000_0000;
      // lazy save: read forces preservation of the live copy
      save_request_r <= fp_rd & lazy_save_enable; // see [RULE18]
      // fp work while access not granted faults
      usage_fault_r <= (fp_instr | fp_rd | fp_wr) & ~access_allowed; // see [RULE21]
      fp_enabled_r  <= acc_ok(fp_coproc_low, 1'b1) & acc_ok(fp_coproc_high, 1'b1); // see [RULE11]
      // mode controls mirror the live status
      alt_half_format_r    <= status_nxt[`FPSC_BIT_ALT_HALF]; // see [RULE3]
      default_nan_select_r <= status_nxt[`FPSC_BIT_DNAN]; // see [RULE4]
      flush_denormals_r    <= status_nxt[`FPSC_BIT_FLUSH]; // see [RULE5]
      round_select_r       <= status_nxt[`FPSC_ROUND_SELECT_HI:`FPSC_ROUND_SELECT_LO]; // see [RULE6]
      fp_irq_r             <= irq_any; // see [RULE23]
    end
  end

endmodule
`default_nettype wire

// file: fpsc_status_control_assertions.sv
// port-level concurrent checks for the fp status/control block
`timescale 1ns/1ns
`default_nettype none
module fpsc_status_control_assertions
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        fp_wr,
  input wire logic        fp_rd,
  input wire logic        cmp_valid,
  input wire logic        exc_valid,
  input wire logic        ctx_entry,
  input wire logic        fp_instr,
  input wire logic        fp_instr_priv,
  input wire logic        sys_wr,
  input wire logic        sys_rd,
  input wire logic        sys_priv,
  input wire logic [31:0] fp_wdata,
  input wire logic [1:0]  cmp_result,
  input wire logic [7:0]  exc_flags,
  input wire logic [31:0] fp_rdata_r,
  input wire logic [31:0] sys_rdata_r,
  input wire logic        sys_err_r,
  input wire logic        usage_fault_r,
  input wire logic        fp_enabled_r,
  input wire logic [1:0]  round_select_r,
  input wire logic        fp_irq_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // privileged core with the unit enabled
  wire       ok = fp_enabled_r && fp_instr_priv;
  wire [1:0] wr_round = fp_wdata[23:22];
  // expected condition flags for each compare outcome
  function automatic logic [3:0] flags_of(input logic [1:0] r);
    flags_of = (r == 2'h0) ? 4'h6 : (r == 2'h1) ? 4'h8 : (r == 2'h2) ? 4'h2 : 4'h3;
  endfunction
  chk_fp_rd_idle: assert property (!fp_rd |=> fp_rdata_r == 32'h0)
    else $error("fp read data not zero when idle");
  chk_sys_rd_idle: assert property (!sys_rd |=> sys_rdata_r == 32'h0)
    else $error("sys read data not zero when idle");
  chk_reserved_zero: assert property (fp_rd |=> (fp_rdata_r & 32'h083f_ff60) == 32'h0)
    else $error("reserved status bits read nonzero");
  chk_disabled_fault: assert property (fp_instr && !fp_enabled_r |=> usage_fault_r)
    else $error("no usage fault while disabled");
  chk_unpriv_refused: assert property ((sys_wr || sys_rd) && !sys_priv |=> sys_err_r)
    else $error("unprivileged access not refused");
  chk_exc_irq: assert property (exc_valid && exc_flags[1] && ok |=> ##1 fp_irq_r)
    else $error("divide by zero did not raise irq");
  chk_irq_clears: assert property (fp_wr && fp_wdata[7:0] == 8'h0 && !exc_valid && ok |=> ##1 !fp_irq_r)
    else $error("irq stayed after sticky clear");
  chk_cmp_flags: assert property (cmp_valid && ok ##1 !(fp_wr || cmp_valid || fp_rd || ctx_entry)
    ##1 fp_rd |=> fp_rdata_r[31:28] == flags_of($past(cmp_result, 3)))
    else $error("condition flags wrong after compare");
  chk_round_mode: assert property (fp_wr && ok |=> round_select_r == $past(wr_round))
    else $error("rounding mode output not updated");
  cover property (fp_irq_r);
  cover property (usage_fault_r);
  cover property (sys_err_r);
endmodule
`default_nettype wire

// file: fpsc_core_model.sv
// core and system-bus model driving the fp status block
`timescale 1ns/1ns
`default_nettype none
module fpsc_core_model
(
  input  wire logic        mclk,
  output var  logic        fp_wr,
  output var  logic        fp_rd,
  output var  logic        cmp_valid,
  output var  logic        exc_valid,
  output var  logic        ctx_entry,
  output var  logic        fp_instr,
  output var  logic        fp_instr_priv,
  output var  logic        sys_wr,
  output var  logic        sys_rd,
  output var  logic        sys_priv,
  output var  logic [7:0]  sys_addr,
  output var  logic [31:0] fp_wdata,
  output var  logic [31:0] sys_wdata,
  output var  logic [1:0]  cmp_result,
  output var  logic [7:0]  exc_flags
);
  // all requests idle at time zero
  initial {fp_wr, fp_rd, cmp_valid, exc_valid, ctx_entry, fp_instr, fp_instr_priv, sys_wr,
           sys_rd, sys_priv, sys_addr, fp_wdata, sys_wdata, cmp_result, exc_flags} = '0;
  // one request of kind k held for one cycle from a falling edge
  task op(input int k, input logic [31:0] d, input logic [7:0] a, input logic p);
    begin
      @(negedge mclk);
      {ctx_entry, fp_instr, sys_rd, sys_wr, exc_valid, cmp_valid, fp_rd, fp_wr} = 8'h01 << k;
      {sys_addr, sys_priv, fp_instr_priv} = {a, p, p};
      {fp_wdata, sys_wdata, cmp_result, exc_flags} = {d, d, d[1:0], d[7:0]};
      @(negedge mclk);
      {ctx_entry, fp_instr, sys_rd, sys_wr, exc_valid, cmp_valid, fp_rd, fp_wr} = 8'h00;
      {fp_wdata, sys_wdata} = {~d, ~d}; // released data must not echo the last value
    end
  endtask
endmodule
`default_nettype wire

// file: fpsc_status_control_tb.sv
// self-checking bench for the fp status/control block
`timescale 1ns/1ns
`default_nettype none
module fpsc_status_control_tb;
  localparam int WR = 0, RD = 1, CMP = 2, EXC = 3, SW = 4, SR = 5, INS = 6, CTX = 7;
  logic        mclk = 1'b0, reset_n = 1'b0, fp_q = 1'b0, sys_q = 1'b0;
  wire         fp_wr, fp_rd, cmp_valid, exc_valid, ctx_entry, fp_instr, fp_instr_priv;
  wire         sys_wr, sys_rd, sys_priv, sys_err_r, usage_fault_r, fp_enabled_r, fp_irq_r;
  wire         alt_half_format_r, default_nan_select_r, flush_denormals_r, save_request_r;
  wire  [7:0]  sys_addr, exc_flags;
  wire  [1:0]  cmp_result, round_select_r;
  wire  [31:0] fp_wdata, sys_wdata, fp_rdata_r, sys_rdata_r;
  logic [31:0] exp_q[$];
  logic [31:0] rnd = 32'h37da;
  logic [3:0]  nzcv [4] = '{4'h6, 4'h8, 4'h2, 4'h3};
  logic [31:0] src [6] = '{32'h01, 32'h10, 32'h80, 32'h08, 32'h04, 32'h02};
  logic [31:0] cfg [2] = '{32'h4000_0000, 32'h8000_0000};
  int          error_cnt = 0, total_checks = 0, cycles = 0;
  always #4 mclk = ~mclk;
  fpsc_status_control fpsc_status_control_i (.*);
  fpsc_core_model fpsc_core_model_i (.*);
  task chk(input logic [31:0] e, input logic [31:0] g);
    begin
      total_checks++;
      if (g !== e)
      begin
        error_cnt++;
        $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // xorshift step for random stimulus
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task op(input int k, input logic [31:0] d, input logic [7:0] a = 8'h0, input logic p = 1'b1);
    fpsc_core_model_i.op(k, d, a, p);
  endtask
  // read request with its expected data noted first
  task rd(input int k, input logic [31:0] e, input logic [7:0] a = 8'h0);
    begin
      exp_q.push_back(e);
      op(k, 32'h0, a);
    end
  endtask
  // read strobes noted at the edge, with a cycle ceiling against hangs
  always @(posedge mclk)
  begin
    fp_q <= fp_rd;
    sys_q <= sys_rd;
    if (++cycles > 2000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  // read results compared with the oldest note
  always @(negedge mclk)
  begin
    if (fp_q || sys_q)
      chk(exp_q.pop_front(), fp_q ? fp_rdata_r : sys_rdata_r);
  end
  initial
  begin
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    op(INS, 32'h0);
    chk(1'b1, usage_fault_r);
    rd(SR, 32'h0, 8'h0c);
    op(SW, 32'h00f0_0000, 8'h88, 1'b0);
    chk(1'b1, sys_err_r);
    op(SW, 32'h00f0_0000, 8'h99);
    chk(1'b1, sys_err_r);
    op(SW, 32'h00f0_0000, 8'h88);
    @(negedge mclk);
    chk(1'b1, fp_enabled_r);
    op(SW, 32'h0, 8'h04);
    op(SW, 32'h07c0_0000, 8'h0c);
    op(CTX, 32'h0);
    rd(RD, 32'h07c0_0000);
    repeat (4)
    begin
      rnd = xs(rnd);
      op(WR, rnd);
      chk(rnd[26:22], {alt_half_format_r, default_nan_select_r, flush_denormals_r,
          round_select_r});
      rd(RD, rnd & 32'hf7c0_009f);
    end
    for (int r = 0; r < 4; r++)
    begin
      op(WR, 32'h0);
      op(CMP, r);
      rd(RD, {nzcv[r], 28'h0});
    end
    foreach (src[i])
    begin
      op(WR, 32'h0);
      op(EXC, src[i]);
      @(negedge mclk);
      chk(|(src[i] & 32'h8e), fp_irq_r);
    end
    rd(RD, 32'h02);
    op(WR, 32'h0);
    @(negedge mclk);
    chk(1'b0, fp_irq_r);
    foreach (cfg[i])
    begin
      op(SW, cfg[i], 8'h04);
      op(EXC, 32'h02);
      rd(RD, 32'h02);
      chk(cfg[i][30], save_request_r);
      rd(RD, 32'h0);
    end
    stop_test();
  end
endmodule
bind fpsc_status_control fpsc_status_control_assertions fpsc_status_control_assertions_i (.*);
`default_nettype wire
